//--- dv/ratioed_sync_pulse_crossing_props.sv
// Concurrent checks on the sync enables between the clock unit and the cluster end.
`timescale 1ns/10ps
module ratioed_sync_pulse_crossing_props #(
  parameter int DIO_DIV = sync_pulse_pkg::DIO_DIV_DEFAULT,
  parameter int IO_DIV  = sync_pulse_pkg::IO_DIV_DEFAULT,
  parameter int SYS_DIV = sync_pulse_pkg::SYS_DIV_DEFAULT
) (
  input logic clk,
  input logic rst_n,
  input logic memOutEnable,
  input logic memInEnable,
  input logic headerDioEnable,
  input logic headerIoEnable,
  input logic dioClockTick,
  input logic ioClockTick,
  input logic coreToSysPulse,
  input logic sysToCorePulse,
  input logic syncStable
);
  localparam int DIO_GAP = DIO_DIV - 1;
  localparam int IO_GAP  = IO_DIV - 1;
  localparam int SYS_GAP = SYS_DIV - 1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_mem_pair;
    memOutEnable == memInEnable;
  endproperty
  a_mem_pair: assert property (p_mem_pair) else $error("memory enables differ");

  // Slot spacing stays between 2 and 6 core cycles for every ratio of 8 to 21.
  property p_mem_gap;
    memOutEnable |=> !memOutEnable ##[1:5] memOutEnable;
  endproperty
  a_mem_gap: assert property (p_mem_gap) else $error("memory slot spacing wrong");

  property p_dio_period;
    headerDioEnable |=> !headerDioEnable ##DIO_GAP headerDioEnable;
  endproperty
  a_dio_period: assert property (p_dio_period) else $error("dio enable period wrong");

  property p_io_period;
    headerIoEnable |=> !headerIoEnable ##IO_GAP headerIoEnable;
  endproperty
  a_io_period: assert property (p_io_period) else $error("io enable period wrong");

  property p_dio_tick;
    headerDioEnable |=> dioClockTick;
  endproperty
  a_dio_tick: assert property (p_dio_tick) else $error("dio tick not after enable");

  property p_io_tick;
    headerIoEnable |=> ioClockTick;
  endproperty
  a_io_tick: assert property (p_io_tick) else $error("io tick not after enable");

  property p_tick_nest;
    ioClockTick |-> dioClockTick;
  endproperty
  a_tick_nest: assert property (p_tick_nest) else $error("io tick off dio edge");

  property p_sys_pair;
    coreToSysPulse == sysToCorePulse;
  endproperty
  a_sys_pair: assert property (p_sys_pair) else $error("system pulses differ");

  property p_sys_period;
    coreToSysPulse |=> !coreToSysPulse ##SYS_GAP coreToSysPulse;
  endproperty
  a_sys_period: assert property (p_sys_period) else $error("system pulse period wrong");

  property p_stable_hold;
    syncStable |=> syncStable;
  endproperty
  a_stable_hold: assert property (p_stable_hold) else $error("sync stable dropped");

  property p_stable_pos;
    $rose(syncStable) |-> ##2 coreToSysPulse;
  endproperty
  a_stable_pos: assert property (p_stable_pos) else $error("stable before pulses");

  c_mem: cover property (memOutEnable ##2 memOutEnable);
  c_stable: cover property ($rose(syncStable));
  c_ticks: cover property (ioClockTick && dioClockTick);
  c_sys: cover property (coreToSysPulse && syncStable);
endmodule

//--- dv/ratioed_sync_pulse_crossing_tb_top.sv
// Testbench joining the pulse generator and the cluster end across their interface.
`timescale 1ns/10ps
module ratioed_sync_pulse_crossing_tb_top;
  localparam int DIOD = sync_pulse_pkg::DIO_DIV_DEFAULT;
  localparam int IOD  = sync_pulse_pkg::IO_DIV_DEFAULT;
  localparam int SYSD = sync_pulse_pkg::SYS_DIV_DEFAULT;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [4:0] coreToMemRatio = 5'h0b;
  logic       alignPoint = 1'b0;
  logic       ratioError;
  logic       dioTickUse;
  logic       ioTickUse;
  logic       resetRelease;
  logic [7:0] din [8];
  logic [7:0] dout [8];
  logic [7:0] expd [8];
  logic [7:0] dprev [8];
  int         err_total = 0;
  int         checked = 0;
  int         seed = 53328;
  int         ratioN;
  int         plan [12] = '{8, 21, 11, 0, 0, 0, 0, 0, 0, 0, 22, 7};

  always #25 clk = ~clk;

  sync_pulse_if sync_pulse_if_i ();
  sync_pulse_gen sync_pulse_gen_i (
    .clk(clk), .rst_n(rst_n), .coreToMemRatio(coreToMemRatio), .alignPoint(alignPoint),
    .link(sync_pulse_if_i), .ratioError(ratioError));
  cluster_sync_end cluster_sync_end_i (
    .clk(clk), .rst_n(rst_n), .link(sync_pulse_if_i),
    .coreToMemData(din[0]), .memLaunchData(dout[0]), .memToCoreData(din[1]),
    .memCaptureData(dout[1]), .coreToDioData(din[2]), .dioLaunchData(dout[2]),
    .dioToCoreData(din[3]), .dioCaptureData(dout[3]), .coreToIoData(din[4]),
    .ioLaunchData(dout[4]), .ioToCoreData(din[5]), .ioCaptureData(dout[5]),
    .coreToSysData(din[6]), .sysLaunchData(dout[6]), .sysToCoreData(din[7]),
    .sysCaptureData(dout[7]), .dioClockTick(dioTickUse), .ioClockTick(ioTickUse),
    .resetRelease(resetRelease));
  ratioed_sync_pulse_crossing_props ratioed_sync_pulse_crossing_props_i (
    .clk(clk), .rst_n(rst_n), .memOutEnable(sync_pulse_if_i.memOutEnable),
    .memInEnable(sync_pulse_if_i.memInEnable), .headerDioEnable(sync_pulse_if_i.headerDioEnable),
    .headerIoEnable(sync_pulse_if_i.headerIoEnable), .dioClockTick(sync_pulse_if_i.dioClockTick),
    .ioClockTick(sync_pulse_if_i.ioClockTick), .coreToSysPulse(sync_pulse_if_i.coreToSysPulse),
    .sysToCorePulse(sync_pulse_if_i.sysToCorePulse), .syncStable(sync_pulse_if_i.syncStable));

  function automatic bit ratioOk();
    return ratioN >= 8 && ratioN <= 21;
  endfunction

  function automatic bit memHit(int n, int p);
    int t [4];
    case (n)
      8: t = '{1, 3, 5, 7};
      9: t = '{1, 3, 6, 8};
      10: t = '{1, 4, 6, 9};
      11, 12: t = '{1, 4, 7, 10};
      13: t = '{2, 5, 8, 11};
      14: t = '{2, 5, 9, 12};
      15: t = '{2, 6, 9, 13};
      16: t = '{2, 6, 10, 14};
      17: t = '{2, 6, 11, 15};
      18: t = '{2, 7, 11, 16};
      19, 20: t = '{2, 7, 12, 17};
      default: t = '{3, 8, 13, 18};
    endcase
    return p == t[0] || p == t[1] || p == t[2] || p == t[3];
  endfunction

  // Header enable of path k (0 memory, 1 double-IO, 2 IO, 3 system) in cycle c after align.
  function automatic bit expEn(int k, int c);
    if (!ratioOk()) return 1'b0;
    if (k == 3) return c >= 3 && (c - 1) % SYSD == 2;
    if (c < 8) return 1'b0;
    // The header leads the point of use by one cycle, so its phase is simply c.
    if (k == 0) return memHit(ratioN, c % ratioN);
    return (c - 8) % (k == 1 ? DIOD : IOD) == (k == 1 ? DIOD - 1 : IOD - 1);
  endfunction

  function automatic bit expTick(int div, int c);
    return ratioOk() && c >= 8 && (c - 8) % div == 0;
  endfunction

  task automatic chk1(string name, logic seen, logic exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic chk8(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Each run starts from reset, so later runs also exercise a reset in mid-pattern.
  task automatic run(int n);
    int dly;
    int c;
    dly = 1 + ($unsigned($random(seed)) % 8);
    ratioN = n;
    rst_n = 1'b0;
    coreToMemRatio = 5'(n);
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int j = 0; j < 8; j++) begin
      expd[j] = 8'h00;
    end
    for (int cyc = 1; cyc < 130; cyc++) begin
      @(negedge clk);
      c = cyc - dly;
      for (int j = 0; j < 8; j++) begin
        if (expEn(j / 2, c - (j < 6 ? 2 : 3))) begin
          expd[j] = dprev[j];
        end
        chk8($sformatf("data%0d", j), dout[j], expd[j]);
        din[j] = 8'($random(seed));
        dprev[j] = din[j];
      end
      alignPoint = (c == 0);
      chk1("memOut", sync_pulse_if_i.memOutEnable, expEn(0, c));
      chk1("memIn", sync_pulse_if_i.memInEnable, expEn(0, c));
      chk1("dioEn", sync_pulse_if_i.headerDioEnable, expEn(1, c));
      chk1("ioEn", sync_pulse_if_i.headerIoEnable, expEn(2, c));
      chk1("dioTick", sync_pulse_if_i.dioClockTick, expTick(DIOD, c));
      chk1("ioTick", sync_pulse_if_i.ioClockTick, expTick(IOD, c));
      chk1("dioTickUse", dioTickUse, expTick(DIOD, c - 1));
      chk1("ioTickUse", ioTickUse, expTick(IOD, c - 1));
      chk1("sysOut", sync_pulse_if_i.coreToSysPulse, expEn(3, c));
      chk1("sysIn", sync_pulse_if_i.sysToCorePulse, expEn(3, c));
      chk1("stable", sync_pulse_if_i.syncStable, ratioOk() && c >= 33);
      chk1("release", resetRelease, ratioOk() && c >= 34);
      if (cyc >= 2) begin
        chk1("ratioError", ratioError, !ratioOk());
      end
    end
  endtask

  initial begin
    for (int j = 0; j < 8; j++) begin
      din[j] = 8'h00;
      dprev[j] = 8'h00;
    end
    foreach (plan[i]) begin
      run(plan[i] == 0 ? 8 + ($unsigned($random(seed)) % 14) : plan[i]);
    end
    summarize();
  end

  // A hang is cut short well past the longest plan.
  initial begin
    #500000;
    err_total++;
    summarize();
  end
endmodule

//--- logic/cluster_sync_end.sv
// Cluster end: local enable flops, transfer flops and reset unit pulse staging.
`timescale 1ns/10ps
module cluster_sync_end #(
  parameter int DATA_W = 8
) (
  input  logic              clk,
  input  logic              rst_n,
  sync_pulse_if.cluster     link,
  input  logic [DATA_W-1:0] coreToMemData,
  output logic [DATA_W-1:0] memLaunchData,
  input  logic [DATA_W-1:0] memToCoreData,
  output logic [DATA_W-1:0] memCaptureData,
  input  logic [DATA_W-1:0] coreToDioData,
  output logic [DATA_W-1:0] dioLaunchData,
  input  logic [DATA_W-1:0] dioToCoreData,
  output logic [DATA_W-1:0] dioCaptureData,
  input  logic [DATA_W-1:0] coreToIoData,
  output logic [DATA_W-1:0] ioLaunchData,
  input  logic [DATA_W-1:0] ioToCoreData,
  output logic [DATA_W-1:0] ioCaptureData,
  input  logic [DATA_W-1:0] coreToSysData,
  output logic [DATA_W-1:0] sysLaunchData,
  input  logic [DATA_W-1:0] sysToCoreData,
  output logic [DATA_W-1:0] sysCaptureData,
  output logic              dioClockTick,
  output logic              ioClockTick,
  output logic              resetRelease
);

  logic                                   memOutLocal;
  logic                                   memInLocal;
  logic                                   dioLocal;
  logic                                   ioLocal;
  logic [sync_pulse_pkg::RST_STAGES-1:0]  coreToSysStage;
  logic [sync_pulse_pkg::RST_STAGES-1:0]  sysToCoreStage;

  // One flop of the header dio enable feeds both directions, keeping them in lockstep.
  wire coreToDioEnable = dioLocal;
  wire dioToCoreEnable = dioLocal;
  wire coreToIoEnable  = ioLocal;
  wire ioToCoreEnable  = ioLocal;
  wire coreToSysEnable = coreToSysStage[sync_pulse_pkg::RST_STAGES-1];
  wire sysToCoreEnable = sysToCoreStage[sync_pulse_pkg::RST_STAGES-1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memOutLocal  <= 1'b0;
      memInLocal   <= 1'b0;
      dioLocal     <= 1'b0;
      ioLocal      <= 1'b0;
      dioClockTick <= 1'b0;
      ioClockTick  <= 1'b0;
      resetRelease <= 1'b0;
    end else begin
      memOutLocal  <= link.memOutEnable;
      memInLocal   <= link.memInEnable;
      dioLocal     <= link.headerDioEnable;
      ioLocal      <= link.headerIoEnable;
      dioClockTick <= link.dioClockTick;
      ioClockTick  <= link.ioClockTick;
      resetRelease <= link.syncStable;
    end
  end

  // Two flops in series stage each system pulse in the reset unit, delaying it two cycles.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreToSysStage <= '0;
      sysToCoreStage <= '0;
    end else begin
      coreToSysStage <= {coreToSysStage[0], link.coreToSysPulse};
      sysToCoreStage <= {sysToCoreStage[0], link.sysToCorePulse};
    end
  end

  // Launch flops load on the core edge after the enable; capture flops likewise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memLaunchData  <= '0;
      memCaptureData <= '0;
      dioLaunchData  <= '0;
      dioCaptureData <= '0;
      ioLaunchData   <= '0;
      ioCaptureData  <= '0;
      sysLaunchData  <= '0;
      sysCaptureData <= '0;
    end else begin
      if (memOutLocal) begin
        memLaunchData <= coreToMemData;
      end
      if (memInLocal) begin
        memCaptureData <= memToCoreData;
      end
      if (coreToDioEnable) begin
        dioLaunchData <= coreToDioData;
      end
      if (dioToCoreEnable) begin
        dioCaptureData <= dioToCoreData;
      end
      if (coreToIoEnable) begin
        ioLaunchData <= coreToIoData;
      end
      if (ioToCoreEnable) begin
        ioCaptureData <= ioToCoreData;
      end
      if (coreToSysEnable) begin
        sysLaunchData <= coreToSysData;
      end
      if (sysToCoreEnable) begin
        sysCaptureData <= sysToCoreData;
      end
    end
  end

endmodule

//--- logic/sync_pulse_gen.sv
// Clock unit end: sync pulse generation, five-stage distribution and cluster header stage.
`timescale 1ns/10ps
module sync_pulse_gen #(
  parameter int DIO_DIV     = sync_pulse_pkg::DIO_DIV_DEFAULT,
  parameter int IO_DIV      = sync_pulse_pkg::IO_DIV_DEFAULT,
  parameter int SYS_DIV     = sync_pulse_pkg::SYS_DIV_DEFAULT,
  parameter int PIPE_STAGES = sync_pulse_pkg::PIPE_STAGES
) (
  input  logic                clk,
  input  logic                rst_n,
  input  logic [4:0]          coreToMemRatio,
  input  logic                alignPoint,
  sync_pulse_if.clock_unit    link,
  output logic                ratioError
);

  localparam int         PW       = sync_pulse_pkg::PHASE_W;
  localparam logic [4:0] DIO_LAST = 5'(DIO_DIV - 1);
  localparam logic [4:0] IO_LAST  = 5'(IO_DIV - 1);
  localparam logic [4:0] SYS_LAST = 5'(SYS_DIV - 1);
  localparam logic [4:0] MEM_LEAD = 5'(sync_pulse_pkg::LEAD);
  localparam logic [4:0] DIO_INIT = 5'(sync_pulse_pkg::LEAD % DIO_DIV);
  localparam logic [4:0] IO_INIT  = 5'(sync_pulse_pkg::LEAD % IO_DIV);
  localparam logic [4:0] SYS_INIT = 5'(sync_pulse_pkg::SYS_LEAD % SYS_DIV);

  // Absolute phases of the four memory-domain transfers; both directions share them.
  function automatic logic [19:0] slot_table(input logic [4:0] n);
    case (n)
      5'h08:   slot_table = {5'h01, 5'h03, 5'h05, 5'h07};
      5'h09:   slot_table = {5'h01, 5'h03, 5'h06, 5'h08};
      5'h0a:   slot_table = {5'h01, 5'h04, 5'h06, 5'h09};
      5'h0b:   slot_table = {5'h01, 5'h04, 5'h07, 5'h0a};
      5'h0c:   slot_table = {5'h01, 5'h04, 5'h07, 5'h0a};
      5'h0d:   slot_table = {5'h02, 5'h05, 5'h08, 5'h0b};
      5'h0e:   slot_table = {5'h02, 5'h05, 5'h09, 5'h0c};
      5'h0f:   slot_table = {5'h02, 5'h06, 5'h09, 5'h0d};
      5'h10:   slot_table = {5'h02, 5'h06, 5'h0a, 5'h0e};
      5'h11:   slot_table = {5'h02, 5'h06, 5'h0b, 5'h0f};
      5'h12:   slot_table = {5'h02, 5'h07, 5'h0b, 5'h10};
      5'h13:   slot_table = {5'h02, 5'h07, 5'h0c, 5'h11};
      5'h14:   slot_table = {5'h02, 5'h07, 5'h0c, 5'h11};
      5'h15:   slot_table = {5'h03, 5'h08, 5'h0d, 5'h12};
      default: slot_table = {5'h1f, 5'h1f, 5'h1f, 5'h1f};
    endcase
  endfunction

  // One hit per slot, so one enable per slow cycle.
  function automatic logic slot_hit(input logic [4:0] n, input logic [4:0] ph);
    logic [19:0] pos;
    logic        hit;
    pos = slot_table(n);
    hit = 1'b0;
    for (int k = 0; k < sync_pulse_pkg::SLOTS; k++) begin
      hit = hit | (pos[k*PW +: PW] == ph);
    end
    slot_hit = hit;
  endfunction

  function automatic logic [4:0] step_phase(input logic [4:0] ph, input logic [4:0] last);
    step_phase = (ph == last) ? 5'h00 : ph + 5'h01;
  endfunction

  logic [4:0]                  ratioHeld;
  logic                        ratioTaken;
  sync_pulse_pkg::stable_e     state;
  sync_pulse_pkg::stable_e     next_state;
  logic [5:0]                  fillCount;
  logic [4:0]                  memGen;
  logic [4:0]                  dioGen;
  logic [4:0]                  ioGen;
  logic [4:0]                  sysGen;
  logic [sync_pulse_pkg::EN_W-1:0] genVec;
  logic [sync_pulse_pkg::EN_W-1:0] next_gen;
  logic [sync_pulse_pkg::EN_W-1:0] pipe [PIPE_STAGES];
  logic [sync_pulse_pkg::EN_W-1:0] header;
  logic                        coreToSys;
  logic                        sysToCore;
  logic                        stable;

  wire       ratioOk  = (ratioHeld >= sync_pulse_pkg::RATIO_MIN) &&
                        (ratioHeld <= sync_pulse_pkg::RATIO_MAX);
  wire       aligned  = (state != sync_pulse_pkg::ST_WAIT_ALIGN);
  wire       restart  = alignPoint && ratioOk;
  wire [4:0] memLast  = ratioHeld - 5'h01;
  // The memGen, dioGen and ioGen counters run LEAD phases ahead, so they name the phase at the point of use.
  wire [4:0] memInit  = (ratioHeld > MEM_LEAD) ? MEM_LEAD : 5'h00;
  wire       memHit   = aligned && slot_hit(ratioHeld, memGen);
  wire       fillDone = (fillCount == sync_pulse_pkg::STABLE_WAIT - 6'h01);

  // The ratio is a strap: it is taken on the first clock after reset release and then frozen.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ratioHeld  <= sync_pulse_pkg::RATIO_DEFAULT;
      ratioTaken <= 1'b0;
    end else if (!ratioTaken) begin
      ratioHeld  <= coreToMemRatio;
      ratioTaken <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ratioError <= 1'b0;
    end else begin
      ratioError <= ratioTaken && !ratioOk;
    end
  end

  // Every phase counter restarts at an alignment point seen with a valid ratio, loading memInit, DIO_INIT, IO_INIT or SYS_INIT on the next cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memGen <= 5'h00;
      dioGen <= 5'h00;
      ioGen  <= 5'h00;
      sysGen <= 5'h00;
    end else if (restart) begin
      memGen <= memInit;
      dioGen <= DIO_INIT;
      ioGen  <= IO_INIT;
      sysGen <= SYS_INIT;
    end else begin
      memGen <= step_phase(memGen, memLast);
      dioGen <= step_phase(dioGen, DIO_LAST);
      ioGen  <= step_phase(ioGen, IO_LAST);
      sysGen <= step_phase(sysGen, SYS_LAST);
    end
  end

  // Enables sit in the last core cycle of each divided period; ticks mark the slow edge.
  always_comb begin
    next_gen                             = '0;
    next_gen[sync_pulse_pkg::EN_MEM_OUT] = memHit;
    next_gen[sync_pulse_pkg::EN_MEM_IN]  = memHit;
    next_gen[sync_pulse_pkg::EN_DIO]     = aligned && (dioGen == DIO_LAST);
    next_gen[sync_pulse_pkg::EN_IO]      = aligned && (ioGen == IO_LAST);
    next_gen[sync_pulse_pkg::EN_DIO_TICK] = aligned && (dioGen == 5'h00);
    next_gen[sync_pulse_pkg::EN_IO_TICK]  = aligned && (ioGen == 5'h00);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      genVec <= '0;
    end else begin
      genVec <= next_gen;
    end
  end

  // Distribution pipeline on the tree taps.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      pipe[0] <= genVec;
      for (int i = 1; i < PIPE_STAGES; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // Header stage; the cluster adds one more flop, hence the single-cycle lead.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      header <= '0;
    end else begin
      header <= pipe[PIPE_STAGES-1];
    end
  end

  // The reset unit sits close by, so these pulses leave straight from one flop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      coreToSys <= 1'b0;
      sysToCore <= 1'b0;
    end else begin
      coreToSys <= aligned && (sysGen == sync_pulse_pkg::SYS_ACTIVE_PHASE);
      sysToCore <= aligned && (sysGen == sync_pulse_pkg::SYS_ACTIVE_PHASE);
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      sync_pulse_pkg::ST_WAIT_ALIGN: begin
        if (restart) begin
          next_state = sync_pulse_pkg::ST_FILL;
        end
      end
      sync_pulse_pkg::ST_FILL: begin
        if (fillDone) begin
          next_state = sync_pulse_pkg::ST_STABLE;
        end
      end
      sync_pulse_pkg::ST_STABLE: begin
        next_state = sync_pulse_pkg::ST_STABLE;
      end
      default: begin
        next_state = sync_pulse_pkg::ST_WAIT_ALIGN;
      end
    endcase
  end

  // Stable is held back until the whole pipeline carries correctly placed pulses.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= sync_pulse_pkg::ST_WAIT_ALIGN;
      fillCount <= 6'h00;
      stable    <= 1'b0;
    end else begin
      state     <= next_state;
      fillCount <= (state == sync_pulse_pkg::ST_FILL) ? fillCount + 6'h01 : 6'h00;
      stable    <= (next_state == sync_pulse_pkg::ST_STABLE);
    end
  end

  assign link.memOutEnable    = header[sync_pulse_pkg::EN_MEM_OUT];
  assign link.memInEnable     = header[sync_pulse_pkg::EN_MEM_IN];
  assign link.headerDioEnable = header[sync_pulse_pkg::EN_DIO];
  assign link.headerIoEnable  = header[sync_pulse_pkg::EN_IO];
  assign link.dioClockTick    = header[sync_pulse_pkg::EN_DIO_TICK];
  assign link.ioClockTick     = header[sync_pulse_pkg::EN_IO_TICK];
  assign link.coreToSysPulse  = coreToSys;
  assign link.sysToCorePulse  = sysToCore;
  assign link.syncStable      = stable;

endmodule

//--- logic/sync_pulse_if.sv
// Interface between the clock unit pulse generator and the cluster transfer end.
`timescale 1ns/10ps
interface sync_pulse_if;
  logic memOutEnable;
  logic memInEnable;
  logic headerDioEnable;
  logic headerIoEnable;
  logic dioClockTick;
  logic ioClockTick;
  logic coreToSysPulse;
  logic sysToCorePulse;
  logic syncStable;

  modport clock_unit (
    output memOutEnable,
    output memInEnable,
    output headerDioEnable,
    output headerIoEnable,
    output dioClockTick,
    output ioClockTick,
    output coreToSysPulse,
    output sysToCorePulse,
    output syncStable
  );

  modport cluster (
    input memOutEnable,
    input memInEnable,
    input headerDioEnable,
    input headerIoEnable,
    input dioClockTick,
    input ioClockTick,
    input coreToSysPulse,
    input sysToCorePulse,
    input syncStable
  );
endinterface

//--- logic/sync_pulse_pkg.sv
// Shared constants for the ratioed sync pulse generator and the cluster transfer end.
package sync_pulse_pkg;

  // Width of every phase counter; holds ratios up to 31 core cycles per four slow cycles.
  localparam int PHASE_W = 5;

  // Core-to-memory ratio N of N:4 that the position lookup covers.
  localparam logic [4:0] RATIO_MIN     = 5'h08;
  localparam logic [4:0] RATIO_MAX     = 5'h15;
  localparam logic [4:0] RATIO_DEFAULT = 5'h0b;

  // Slow cycles in one repeating pattern.
  localparam int SLOTS = 4;

  // Register stages from the pulse generator to the point of use.
  localparam int GEN_STAGES     = 1;
  localparam int PIPE_STAGES    = 5;
  localparam int HEADER_STAGES  = 1;
  localparam int CLUSTER_STAGES = 1;
  localparam int LEAD = GEN_STAGES + PIPE_STAGES + HEADER_STAGES + CLUSTER_STAGES;

  // Core/system pulses skip the tree: one output flop, then two flops in the reset unit.
  localparam int         SYS_LEAD         = 1;
  localparam int         RST_STAGES       = 2;
  localparam logic [4:0] SYS_ACTIVE_PHASE = 5'h02;

  // Cycles after alignment before the pattern is declared stable.
  localparam logic [5:0] STABLE_WAIT = 6'h20;

  // Bit positions of the enable vector carried down the distribution pipeline.
  localparam int EN_MEM_OUT  = 0;
  localparam int EN_MEM_IN   = 1;
  localparam int EN_DIO      = 2;
  localparam int EN_IO       = 3;
  localparam int EN_DIO_TICK = 4;
  localparam int EN_IO_TICK  = 5;
  localparam int EN_W        = 6;

  // Default integer dividers of the double-IO, IO and system clocks.
  localparam int DIO_DIV_DEFAULT = 2;
  localparam int IO_DIV_DEFAULT  = 4;
  localparam int SYS_DIV_DEFAULT = 8;

  typedef enum logic [1:0] {
    ST_WAIT_ALIGN = 2'b00,
    ST_FILL       = 2'b01,
    ST_STABLE     = 2'b11
  } stable_e;

endpackage
